// ==== hdl/pct_regs.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pct_consts.svh"

// Summary of operation
// [R1] Extended duplex forces full with forced-100 partner
// [R2] Bit 9 enables robust crossover resolution
// [R3] Bit 8 enables fast crossover resolution
// [R4] Bit 7 makes pad interrupt output
// [R5] Bit 6 forces interrupt pin asserted
// [R6] Reserved read-only bits ignore writes, read zero
// [R7] Writing bit 0 launches cable test
// [R8] Done bit reads completion, resets to one
// [R9] Fail bit reads test failure, resets zero
// [R10] Bit 15 full reset with registers, self-clears
// [R11] Bit 14 restart keeping registers, self-clears
// [R12] Lane field bit 7 drives all lanes
// [R13] Bits 6:5 pick single lane A-D
// [R14] Timer field sets 32 ms steps, reset 0xF
// [R15] Software enables robust mode before timer use
// [R16] Software preserves reserved bits by read-modify-write
module pct_regs
    import pct_pkg::*;
#(
    parameter int P_MS_CYCLES = `PCT_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Duplex resolution
    input  wire logic        i_partner_forced_100,
    input  wire logic        i_std_duplex_full,
    output logic             o_duplex_full,
    // Crossover resolution
    input  wire logic        i_xover_resolving,
    output logic             o_robust_xover_en,
    output logic             o_fast_xover_en,
    output logic             o_xover_timeout,
    // Cable reflectometry engine
    output logic             o_cable_test_launch,
    input  wire logic        i_cable_test_end,
    input  wire logic        i_cable_test_bad,
    // Device resets
    output logic             o_full_reset,
    output logic             o_restart,
    // Test lanes A..D
    output logic      [3:0]  o_test_lane_en,
    // Shared interrupt / power-down pad
    input  wire logic        i_pad_in,
    output logic             o_pad_out,
    output logic             o_pad_oe_n,
    output logic             o_powerdown,
    // Interrupt
    output logic             o_irq
);

    localparam int DW = (P_MS_CYCLES > 1) ? $clog2(P_MS_CYCLES) : 1;
    localparam logic [DW-1:0] C_DIV_LAST = DW'(P_MS_CYCLES - 1);

    typedef struct packed {
        logic [15:0]          config_three;
        logic                 done;
        logic                 fail;
        pct_ct_e              ct;
        logic                 launch;
        logic                 full_rst;
        logic                 restart;
        logic [15:0]          tch;
        logic [3:0]           lanes;
        logic [15:0]          xtmr;
        logic [`PCT_IRQ_W-1:0] istat;
        logic [`PCT_IRQ_W-1:0] imask;
        logic [15:0]          rdata;
        logic [DW-1:0]        div;
        pct_xt_e              xt;
        logic [9:0]           xms;
        logic                 xto;
        logic                 dup;
        logic                 pad_s1;
        logic                 pad_s2;
        logic                 pwdn;
    } pct_state_s;

    function automatic pct_state_s pct_defaults();
        pct_state_s st;
        st      = '0;
        st.done = `PCT_DONE_RST; // [R8]
        st.fail = 1'b0; // [R9]
        st.ct   = CT_IDLE;
        st.xt   = XT_IDLE;
        st.tch  = `PCT_TCH_RST;
        st.lanes = pct_lanes(st.tch[7:5]);
        st.xtmr = `PCT_XTMR_RST; // [R14]
        return st;
    endfunction

    // Lane enables from the 3-bit select field
    function automatic logic [3:0] pct_lanes(input logic [2:0] sel);
        logic [3:0] l;
        l = 4'h0;
        if (sel[2]) begin
            l = 4'hf; // [R12]
        end else begin
            l[sel[1:0]] = 1'b1; // [R13]
        end
        return l;
    endfunction

    // Timeout length in ms: (code + 1) steps of 32 ms, top code capped
    function automatic logic [9:0] pct_xover_ms(input logic [3:0] code);
        logic [9:0] ms;
        ms = 10'(code) * 10'(`PCT_STEP_MS) + 10'(`PCT_STEP_MS); // [R14]
        // Top code would otherwise run one step past the longest span
        if (ms > 10'(`PCT_MAX_MS)) begin
            ms = 10'(`PCT_MAX_MS); // [R14]
        end
        return ms;
    endfunction

    // Strobe qualified by one register offset
    function automatic logic pct_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] offs
    );
        return strobe && (addr == offs);
    endfunction

    // Readable view of config_three: stored bits plus engine status
    function automatic logic [15:0] pct_config_three_view(
        input logic [15:0] config_three,
        input logic        done,
        input logic        fail
    );
        logic [15:0] v;
        v = config_three & `PCT_CONFIG_THREE_RW; // [R6]
        v[`PCT_B_DONE] = done; // [R8]
        v[`PCT_B_FAIL] = fail; // [R9]
        return v;
    endfunction

    // Readable view of reset_control: only the self-clearing bits
    function automatic logic [15:0] pct_ctrl_view(
        input logic full_rst,
        input logic restart
    );
        logic [15:0] v;
        v = 16'h0000; // [R6]
        v[`PCT_B_FULL_RST] = full_rst;
        v[`PCT_B_RESTART] = restart;
        return v;
    endfunction

    // Extended ability only widens the standard decision
    function automatic logic pct_duplex(
        input logic ext_fd,
        input logic forced_100,
        input logic std_full
    );
        return (ext_fd && forced_100) || std_full; // [R1]
    endfunction

    // Sticky status; an event in the clearing cycle survives
    function automatic logic [`PCT_IRQ_W-1:0] pct_sticky(
        input logic [`PCT_IRQ_W-1:0] old_bits,
        input logic [`PCT_IRQ_W-1:0] clr_bits,
        input logic [`PCT_IRQ_W-1:0] set_bits
    );
        return (old_bits & ~clr_bits) | set_bits;
    endfunction

    pct_state_s q;
    pct_state_s s;
    pct_state_s d;

    logic                  tick;
    logic                  xactive;
    logic [`PCT_IRQ_W-1:0] iset;
    logic [`PCT_IRQ_W-1:0] iclr;
    logic                  irq_any;
    logic                  wr_config_three;
    logic                  wr_ctrl;
    logic                  wr_tch;
    logic                  wr_xtmr;
    logic                  wr_imask;
    logic                  rd_config_three;
    logic                  rd_ctrl;
    logic                  rd_tch;
    logic                  rd_xtmr;
    logic                  rd_istat;
    logic                  rd_imask;

    always_comb begin
        // A pending full reset reloads defaults; a bus write in that cycle still lands on them
        s = q.full_rst ? pct_defaults() : q; // [R10]
        d = s;
        iset = '0;
        iclr = '0;
        d.rdata = 16'h0000;
        d.launch = 1'b0;
        d.xto = 1'b0;
        d.full_rst = 1'b0; // [R10]
        d.restart = 1'b0; // [R11]

        // Offset decode, shared with the cable test engine
        wr_config_three  = pct_hit(i_wr, i_addr, `PCT_A_CONFIG_THREE);
        wr_ctrl  = pct_hit(i_wr, i_addr, `PCT_A_CTRL);
        wr_tch   = pct_hit(i_wr, i_addr, `PCT_A_TCH);
        wr_xtmr  = pct_hit(i_wr, i_addr, `PCT_A_XTMR);
        wr_imask = pct_hit(i_wr, i_addr, `PCT_A_IMASK);
        rd_config_three  = pct_hit(i_rd, i_addr, `PCT_A_CONFIG_THREE);
        rd_ctrl  = pct_hit(i_rd, i_addr, `PCT_A_CTRL);
        rd_tch   = pct_hit(i_rd, i_addr, `PCT_A_TCH);
        rd_xtmr  = pct_hit(i_rd, i_addr, `PCT_A_XTMR);
        rd_istat = pct_hit(i_rd, i_addr, `PCT_A_ISTAT);
        rd_imask = pct_hit(i_rd, i_addr, `PCT_A_IMASK);

        // Register writes
        if (wr_config_three) begin
            d.config_three = i_wdata & `PCT_CONFIG_THREE_RW; // [R6]
        end else if (wr_ctrl) begin
            d.full_rst = i_wdata[`PCT_B_FULL_RST]; // [R10]
            d.restart = i_wdata[`PCT_B_RESTART]; // [R11]
        end else if (wr_tch) begin
            d.tch = i_wdata;
        end else if (wr_xtmr) begin
            d.xtmr = i_wdata; // [R14]
        end else if (wr_imask) begin
            d.imask = i_wdata[`PCT_IRQ_W-1:0];
        end

        // Lane enables kept in a flop, so the pins never glitch
        d.lanes = pct_lanes(d.tch[7:5]); // [R12] [R13]

        // Register reads, answered next cycle
        if (rd_config_three) begin
            d.rdata = pct_config_three_view(s.config_three, s.done, s.fail);
        end else if (rd_ctrl) begin
            d.rdata = pct_ctrl_view(s.full_rst, s.restart); // [R6]
        end else if (rd_tch) begin
            d.rdata = s.tch;
        end else if (rd_xtmr) begin
            d.rdata = s.xtmr;
        end else if (rd_istat) begin
            d.rdata = {13'h0000, s.istat};
            iclr = s.istat;
        end else if (rd_imask) begin
            d.rdata = {13'h0000, s.imask};
        end

        // Cable test engine
        case (s.ct)
            CT_IDLE: begin
                if (wr_config_three && i_wdata[`PCT_B_LAUNCH]) begin
                    d.ct = CT_RUN; // [R7]
                    d.launch = 1'b1; // [R7]
                    d.done = 1'b0; // [R8]
                    d.fail = 1'b0; // [R9]
                end
            end
            CT_RUN: begin
                // Relaunch while running is ignored
                if (s.restart) begin
                    d.ct = CT_IDLE;
                    d.done = 1'b1;
                    d.fail = 1'b1;
                    iset[`PCT_I_DONE] = 1'b1;
                    iset[`PCT_I_FAIL] = 1'b1;
                end else if (i_cable_test_end) begin
                    d.ct = CT_IDLE;
                    d.done = 1'b1; // [R8]
                    d.fail = i_cable_test_bad; // [R9]
                    iset[`PCT_I_DONE] = 1'b1;
                    iset[`PCT_I_FAIL] = i_cable_test_bad;
                end
            end
            default: begin
                d.ct = CT_IDLE;
            end
        endcase

        // Millisecond divider
        tick = (s.div == C_DIV_LAST);
        d.div = tick ? '0 : s.div + DW'(1);

        // Timer only counts in robust mode
        xactive = s.config_three[`PCT_B_ROBUST] && i_xover_resolving &&
                  !s.restart; // [R15]
        if (!xactive) begin
            d.xt = XT_IDLE;
            d.xms = 10'h000;
        end else begin
            case (s.xt)
                XT_IDLE: begin
                    d.xt = XT_RUN; // [R2]
                    d.xms = 10'h000;
                end
                XT_RUN: begin
                    if (tick) begin
                        if (s.xms + 10'h001 == pct_xover_ms(s.xtmr[3:0])) begin
                            d.xto = 1'b1; // [R14]
                            d.xms = 10'h000;
                            iset[`PCT_I_XTO] = 1'b1;
                        end else begin
                            d.xms = s.xms + 10'h001;
                        end
                    end
                end
                default: begin
                    d.xt = XT_IDLE;
                end
            endcase
        end

        // Sticky status, set beats read-clear
        d.istat = pct_sticky(s.istat, iclr, iset);

        // Duplex decision
        d.dup = pct_duplex(s.config_three[`PCT_B_EXT_FD], i_partner_forced_100,
                           i_std_duplex_full); // [R1]

        // Pad input synchroniser; pad is active low
        d.pad_s1 = i_pad_in;
        d.pad_s2 = s.pad_s1;
        d.pwdn = !s.config_three[`PCT_B_PAD_IRQ] && !s.pad_s2; // [R4]
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= pct_defaults();
        end else begin
            q <= d;
        end
    end

    assign irq_any = |(q.istat & q.imask);
    assign o_irq = irq_any || q.config_three[`PCT_B_FORCE_IRQ]; // [R5]
    assign o_pad_oe_n = !q.config_three[`PCT_B_PAD_IRQ]; // [R4]
    assign o_pad_out = !o_irq; // [R5]
    assign o_powerdown = q.pwdn;
    assign o_rdata = q.rdata;
    assign o_duplex_full = q.dup;
    assign o_robust_xover_en = q.config_three[`PCT_B_ROBUST]; // [R2]
    assign o_fast_xover_en = q.config_three[`PCT_B_FAST]; // [R3]
    assign o_xover_timeout = q.xto;
    assign o_cable_test_launch = q.launch;
    assign o_full_reset = q.full_rst; // [R10]
    assign o_restart = q.restart; // [R11]
    assign o_test_lane_en = q.lanes; // [R12]

endmodule // pct_regs

`default_nettype wire

// ==== hdl/pct_consts.svh ====
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH

// Register offsets
`define PCT_A_CONFIG_THREE      8'h1e
`define PCT_A_CTRL      8'h1f
`define PCT_A_TCH       8'h25
`define PCT_A_XTMR      8'h2c
`define PCT_A_ISTAT     8'h3a
`define PCT_A_IMASK     8'h3b

// Field positions, config_three
`define PCT_B_EXT_FD    11
`define PCT_B_ROBUST    9
`define PCT_B_FAST      8
`define PCT_B_PAD_IRQ   7
`define PCT_B_FORCE_IRQ 6
`define PCT_B_FAIL      2
`define PCT_B_DONE      1
`define PCT_B_LAUNCH    0

// Field positions, reset_control
`define PCT_B_FULL_RST  15
`define PCT_B_RESTART   14

// Field positions, interrupt status and mask
`define PCT_I_DONE      0
`define PCT_I_FAIL      1
`define PCT_I_XTO       2
`define PCT_IRQ_W       3

// Writable masks and reset values
`define PCT_CONFIG_THREE_RW     16'h0bc1
`define PCT_CTRL_RW     16'hc000
`define PCT_TCH_RST     16'h0400
`define PCT_XTMR_RST    16'h141f
`define PCT_DONE_RST    1'b1

// Timing
`define PCT_CLK_NS      10
`define PCT_MS_NS       1000000
`define PCT_MS_CYCLES   (`PCT_MS_NS / `PCT_CLK_NS)
`define PCT_STEP_MS     32
`define PCT_MAX_MS      480

`endif

// ==== hdl/pct_pkg.sv ====
`default_nettype none
package pct_pkg;

    // Cable test engine
    typedef enum logic {
        CT_IDLE = 1'b0,
        CT_RUN  = 1'b1
    } pct_ct_e;

    // Robust crossover timer
    typedef enum logic {
        XT_IDLE = 1'b0,
        XT_RUN  = 1'b1
    } pct_xt_e;

endpackage
`default_nettype wire

// ==== bench/pct_regs_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module pct_regs_sva (
    // Clock, reset and register port
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    // Watched outputs, plus the standard duplex input
    input wire logic        i_std_duplex_full,
    input wire logic        o_duplex_full,
    input wire logic        o_cable_test_launch,
    input wire logic        o_full_reset,
    input wire logic        o_restart,
    input wire logic [3:0]  o_test_lane_en,
    input wire logic        o_pad_oe_n,
    input wire logic        o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_launch;
        o_cable_test_launch |-> $past(i_wr && i_addr == 8'h1e && i_wdata[0]);
    endproperty
    a_launch: assert property (p_launch) else $error("stray launch");
    property p_full;
        i_wr && i_addr == 8'h1f && i_wdata[15]
            |=> o_full_reset ##1 !o_full_reset;
    endproperty
    a_full: assert property (p_full) else $error("full reset pulse");
    property p_restart;
        i_wr && i_addr == 8'h1f && i_wdata[14] && !i_wdata[15]
            |=> o_restart ##1 !o_restart;
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_rdz;
        i_rd && i_addr == 8'h1e |=> o_rdata[5:3] == 3'h0 && !o_rdata[10];
    endproperty
    a_rdz: assert property (p_rdz) else $error("reserved bits set");
    property p_force;
        i_wr && i_addr == 8'h1e && i_wdata[6] |=> o_irq;
    endproperty
    a_force: assert property (p_force) else $error("forced irq low");
    property p_pad;
        i_wr && i_addr == 8'h1e |=> o_pad_oe_n == !$past(i_wdata[7]);
    endproperty
    a_pad: assert property (p_pad) else $error("pad direction");
    property p_lanes;
        o_test_lane_en == 4'hf || $onehot(o_test_lane_en);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane pattern");
    property p_lane_sel;
        i_wr && i_addr == 8'h25 |=> o_test_lane_en ==
            ($past(i_wdata[7]) ? 4'hf : 4'h1 << $past(i_wdata[6:5]));
    endproperty
    a_lane_sel: assert property (p_lane_sel) else $error("lane sel");
    property p_duplex;
        $past(i_std_duplex_full) |-> o_duplex_full;
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex lost");
endmodule // pct_regs_sva
bind pct_regs pct_regs_sva u_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_std_duplex_full(i_std_duplex_full), .o_duplex_full(o_duplex_full),
    .o_cable_test_launch(o_cable_test_launch), .o_full_reset(o_full_reset),
    .o_restart(o_restart), .o_test_lane_en(o_test_lane_en),
    .o_pad_oe_n(o_pad_oe_n), .o_irq(o_irq));
`default_nettype wire

// ==== bench/pct_cable_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pct_cable_model (
    // Clock and control
    input  wire logic       i_clk,
    input  wire logic       i_launch,
    input  wire logic       i_abort,
    input  wire logic [7:0] i_lat,
    input  wire logic       i_fail,
    // Result
    output logic            o_end,
    output logic            o_bad
);
    int   cnt_q  = 0;
    logic flip_q = 1'b0;
    logic end_q  = 1'b0;
    logic bad_q  = 1'b0;
    assign o_end = end_q;
    assign o_bad = bad_q;
    always @(posedge i_clk) begin
        flip_q <= !flip_q;
        end_q  <= 1'b0;
        bad_q  <= flip_q; // Meaningless outside the end pulse
        if (i_launch || i_abort) begin
            cnt_q <= i_abort ? 0 : int'(i_lat);
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q == 1) begin
                end_q <= 1'b1;
                bad_q <= i_fail;
            end
        end
    end
endmodule // pct_cable_model
`default_nettype wire

// ==== bench/pct_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module pct_regs_bench;
    logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_pad_in = 1;
    logic        i_partner_forced_100 = 0, i_std_duplex_full = 0;
    logic        i_xover_resolving = 0, fl = 0;
    logic [7:0]  i_addr = 0, lat = 8'd6;
    logic [15:0] i_wdata = 0, o_rdata, lf = 16'h85bd;
    logic        o_duplex_full, o_robust_xover_en, o_fast_xover_en;
    logic        o_xover_timeout, o_cable_test_launch, end_p, bad_p;
    logic        o_full_reset, o_restart, o_pad_out, o_pad_oe_n;
    logic        o_powerdown, o_irq;
    logic [3:0]  o_test_lane_en;
    logic [7:0]  adr [7] = '{8'h1e, 8'h1f, 8'h25, 8'h2c, 8'h3a, 8'h3b, 8'h10};
    int          mdl [256];
    int          error_cnt = 0, samples_checked = 0;
    pct_regs #(.P_MS_CYCLES(10)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_partner_forced_100(i_partner_forced_100),
        .i_std_duplex_full(i_std_duplex_full), .o_duplex_full(o_duplex_full),
        .i_xover_resolving(i_xover_resolving),
        .o_robust_xover_en(o_robust_xover_en),
        .o_fast_xover_en(o_fast_xover_en), .o_xover_timeout(o_xover_timeout),
        .o_cable_test_launch(o_cable_test_launch), .i_cable_test_end(end_p),
        .i_cable_test_bad(bad_p), .o_full_reset(o_full_reset),
        .o_restart(o_restart), .o_test_lane_en(o_test_lane_en),
        .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n),
        .o_powerdown(o_powerdown), .o_irq(o_irq));
    pct_cable_model u_eng (.i_clk(i_clk), .i_launch(o_cable_test_launch),
        .i_abort(o_restart | o_full_reset), .i_lat(lat), .i_fail(fl),
        .o_end(end_p), .o_bad(bad_p));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic mw(input logic [7:0] a, input logic [15:0] d);
        wr(a, d);
        case (a)
            8'h1e: mdl[a] = (d & 16'h0bc1) | (d[0] ? 0 : mdl[a] & 6);
            8'h25, 8'h2c: mdl[a] = d;
            8'h3b: mdl[a] = d & 7;
            default: ;
        endcase
    endtask
    task automatic rd(input logic [7:0] a, input int e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        `CHK("rdata", e[15:0], o_rdata)
    endtask
    task automatic mreset();
        foreach (mdl[k]) mdl[k] = 0;
        mdl[8'h1e] = 2;
        mdl[8'h25] = 16'h0400;
        mdl[8'h2c] = 16'h141f;
    endtask
    task automatic print_verdict();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        forever #5 i_clk = !i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        int n;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        mreset();
        foreach (adr[k]) rd(adr[k], mdl[adr[k]]);
        repeat (6) begin
            lf = nxt(lf);
            @(posedge i_clk);
            i_pad_in <= lf[3];
            mw(8'h1e, lf & 16'hfffe);
            rd(8'h1e, mdl[8'h1e]);
            repeat (3) @(posedge i_clk);
            #1;
            `CHK("robust", lf[9], o_robust_xover_en)
            `CHK("fast", lf[8], o_fast_xover_en)
            `CHK("oe_n", !lf[7], o_pad_oe_n)
            `CHK("pwdn", !lf[7] && !lf[3], o_powerdown)
            `CHK("irq", lf[6], o_irq)
            `CHK("pad", !lf[6], o_pad_out)
        end
        for (int c = 0; c < 8; c++) begin
            mw(8'h25, {mdl[8'h25][15:8], c[2:0], mdl[8'h25][4:0]});
            rd(8'h25, mdl[8'h25]);
            `CHK("lane", c[2] ? 4'hf : 4'h1 << c[1:0], o_test_lane_en)
        end
        mw(8'h2c, (mdl[8'h2c] & 16'hfff0) | 16'h0001);
        rd(8'h2c, mdl[8'h2c]);
        mw(8'h1e, 16'h0200);
        i_xover_resolving <= 1'b1;
        n = 0;
        while (!o_xover_timeout && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        `CHK("tmr", 1'b1, n >= 620 && n <= 660)
        @(posedge i_clk);
        i_xover_resolving <= 1'b0;
        #1;
        `CHK("irq_mask", 1'b0, o_irq)
        mw(8'h3b, 16'h0004);
        #1;
        `CHK("irq_on", 1'b1, o_irq)
        rd(8'h3a, 4);
        `CHK("irq_clr", 1'b0, o_irq)
        for (int f = 1; f >= 0; f--) begin
            fl = f[0];
            mw(8'h1e, 16'h0001);
            #1;
            `CHK("launch", 1'b1, o_cable_test_launch)
            rd(8'h1e, mdl[8'h1e]);
            repeat (8) @(posedge i_clk);
            mdl[8'h1e] = mdl[8'h1e] | 2 | (f << 2);
            rd(8'h1e, mdl[8'h1e]);
            rd(8'h3a, 1 | (f << 1));
        end
        lat <= 8'd40;
        mw(8'h1e, 16'h0001);
        mw(8'h1f, 16'h4000);
        #1;
        `CHK("restart", 1'b1, o_restart)
        rd(8'h1e, mdl[8'h1e] | 6);
        rd(8'h1f, 0);
        rd(8'h25, mdl[8'h25]);
        mw(8'h1f, 16'h3fff);
        rd(8'h1f, 0);
        mw(8'h1e, 16'h08c0);
        mw(8'h1f, 16'h8000);
        #1;
        `CHK("full_rst", 1'b1, o_full_reset)
        mreset();
        foreach (adr[k]) rd(adr[k], mdl[adr[k]]);
        mw(8'h1e, 16'h0200);
        i_xover_resolving <= 1'b1;
        n = 0;
        while (!o_xover_timeout && n < 6000) begin
            @(negedge i_clk);
            n++;
        end
        `CHK("tmr_top", 1'b1, n >= 4780 && n <= 4820)
        @(posedge i_clk);
        i_xover_resolving <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            lf = nxt(lf);
            @(posedge i_clk);
            i_partner_forced_100 <= k[0];
            i_std_duplex_full    <= lf[0];
            mw(8'h1e, {4'h0, k[1], 11'h0});
            repeat (3) @(posedge i_clk);
            #1;
            `CHK("duplex", k == 3 || lf[0], o_duplex_full)
        end
        print_verdict();
    end
endmodule // pct_regs_bench
`default_nettype wire
